// ### sim/swm_cpu_model.sv
// Interrupt controller and reset source model facing the controller
`timescale 1ns/1ps
`default_nettype none

module swm_cpu_model
	import swm_pkg::*;
#(
	parameter int OSC_CYC = 0
) (
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire swm_irq_type irq_set,
	input  wire logic        irq_load,
	input  wire logic        rst_go,
	input  wire logic        cpu_resume,
	output var  swm_irq_type irq_req,
	output var  logic        reset_source
);
	// Oscillator start, then 100 us at 5 ns, then 16 cycles
	localparam int RST_HOLD = OSC_CYC + 20000 + 16;
	int rst_cnt;

	always_ff @(posedge clock) begin
		if (srst)
			irq_req <= '0;
		else if (irq_load)
			irq_req <= irq_set;
		else if (cpu_resume)
			irq_req.pending <= 1'b0;
	end

	always_ff @(posedge clock) begin
		if (srst)
			rst_cnt <= 0;
		else if (rst_go)
			rst_cnt <= RST_HOLD;
		else if (rst_cnt != 0)
			rst_cnt <= rst_cnt - 1;
	end
	assign reset_source = (rst_cnt != 0);
endmodule

`default_nettype wire

// ### sim/swm_ctrl_props.sv
// Port checker for the sleep and watch mode controller
`timescale 1ns/1ps
`default_nettype none

module swm_ctrl_props
	import swm_pkg::*;
#(
	parameter int PIN_W = 8,
	parameter int IN_W  = 4
) (
	input wire logic              clock,
	input wire logic              srst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire swm_irq_type       irq_req,
	input wire logic              reset_source,
	input wire logic [PIN_W-1:0]  core_pin_out,
	input wire logic [PIN_W-1:0]  core_pin_oe,
	input wire logic [IN_W-1:0]   wake_pin_in,
	input wire logic [PIN_W-1:0]  pin_o,
	input wire logic [PIN_W-1:0]  pin_oe,
	input wire logic [IN_W-1:0]   wake_pin_live,
	input wire swm_clk_ctrl_type  clk_ctrl,
	input wire logic              retain_en,
	input wire logic              entry_refused,
	input wire logic              cpu_resume,
	input wire logic              sys_reset_req,
	input wire logic [HALT_W-1:0] halt_cycles,
	input wire logic [8:0]        mode_state
);
	logic       in_sleep;
	logic       in_low;
	logic       wake_ok;
	logic       wr_pmc;
	logic [1:0] sel_q;
	logic       pin_q;
	logic [8:0] slp_exp;

	default clocking @(posedge clock); endclocking
	default disable iff (srst);

	assign in_sleep = mode_state inside {ST_SLP_MAIN, ST_SLP_PLL, ST_SLP_SUB};
	assign in_low = in_sleep
		|| mode_state inside {ST_TIMEBASE, ST_WATCH, ST_STOP};
	assign wr_pmc = reg_wr && reg_addr == ADDR_PMC && mode_state == ST_RUN;
	assign wake_ok = irq_req.pending && irq_req.level < WAKE_LEVEL && (in_sleep
		|| (mode_state == ST_TIMEBASE && (irq_req.src_watch_timer
		|| irq_req.src_timebase || irq_req.src_external))
		|| (mode_state == ST_WATCH && (irq_req.src_watch_timer
		|| irq_req.src_external))
		|| (mode_state == ST_STOP && irq_req.src_external));
	assign slp_exp = !sel_q[CKS_SUB_BIT] ? ST_SLP_SUB :
		(sel_q[CKS_MAIN_BIT] ? ST_SLP_MAIN : ST_SLP_PLL);

	// Clock select shadow
	always_ff @(posedge clock) begin
		if (srst || mode_state == ST_RESET_SEQ)
			sel_q <= 2'h3;
		else if (reg_wr && reg_addr == ADDR_CLKSEL && mode_state == ST_RUN)
			sel_q <= reg_wdata[1:0];
	end

	// Pin state select shadow
	always_ff @(posedge clock) begin
		if (srst)
			pin_q <= 1'b0;
		else if (wr_pmc)
			pin_q <= reg_wdata[PMC_PIN_BIT];
	end

	sequence wake_seq;
		mode_state == ST_WAKE && cpu_resume ##1 mode_state == ST_RUN && !cpu_resume;
	endsequence
	sequence rst_seq;
		mode_state == ST_RESET_SEQ && sys_reset_req ##1 mode_state == ST_RUN;
	endsequence

	sleep_entry_a: assert property (
		wr_pmc && reg_wdata[7:6] == 2'h1 && reg_wdata[3] && !irq_req.pending
		|=> mode_state == $past(slp_exp)) else $error("wrong sleep variant");
	stop_prio_a: assert property (
		wr_pmc && reg_wdata[7] && !irq_req.pending |=> mode_state == ST_STOP)
		else $error("stop entry missed");
	watch_prio_a: assert property (
		wr_pmc && !reg_wdata[7] && !reg_wdata[3] && !irq_req.pending
		|=> mode_state == ($past(sel_q[0]) ? ST_TIMEBASE : ST_WATCH))
		else $error("watch entry wrong");
	entry_block_a: assert property (
		wr_pmc && irq_req.pending
		&& (reg_wdata[7] || reg_wdata[6] || !reg_wdata[3])
		|=> mode_state == ST_RUN && entry_refused)
		else $error("entry not refused");
	sleep_clk_a: assert property (
		in_sleep |-> !clk_ctrl.cpu_clk_en && clk_ctrl.periph_clk_en && retain_en)
		else $error("sleep clocks wrong");
	watch_clk_a: assert property (
		(mode_state == ST_WATCH |-> clk_ctrl == 8'h0d && retain_en)
		and (mode_state == ST_TIMEBASE |-> clk_ctrl.timebase_en
		&& clk_ctrl.watch_timer_en && clk_ctrl.lvd_en && !clk_ctrl.cpu_clk_en))
		else $error("standby clocks wrong");
	pin_hold_a: assert property (
		in_sleep && $past(in_sleep) && $past(in_sleep, 2)
		|-> $stable(pin_o) && $stable(pin_oe)) else $error("pins moved in sleep");
	pin_hiz_a: assert property (
		mode_state == ST_WATCH && $past(mode_state) == ST_WATCH && pin_q
		|-> pin_oe == '0) else $error("pins not released");
	wake_exit_a: assert property (
		in_low && wake_ok && !reset_source |=> wake_seq)
		else $error("wake sequence wrong");
	mode_stay_a: assert property (
		in_low && !wake_ok && !reset_source |=> $stable(mode_state))
		else $error("mode left without cause");
	reset_exit_a: assert property (
		in_low && reset_source |=> rst_seq) else $error("reset exit wrong");
	fixed_bits_a: assert property (
		reg_rd && reg_addr == ADDR_PMC
		|=> reg_rdata[7:6] == 2'h0 && reg_rdata[4:3] == 2'h3)
		else $error("fixed bits wrong");
	live_in_a: assert property (
		!$past(srst) |-> wake_pin_live == $past(wake_pin_in))
		else $error("wake inputs not live");
endmodule

bind swm_ctrl swm_ctrl_props #(.PIN_W(PIN_W), .IN_W(IN_W)) i_swm_ctrl_props (
	.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.irq_req(irq_req), .reset_source(reset_source),
	.core_pin_out(core_pin_out), .core_pin_oe(core_pin_oe),
	.wake_pin_in(wake_pin_in), .pin_o(pin_o), .pin_oe(pin_oe),
	.wake_pin_live(wake_pin_live), .clk_ctrl(clk_ctrl), .retain_en(retain_en),
	.entry_refused(entry_refused), .cpu_resume(cpu_resume),
	.sys_reset_req(sys_reset_req), .halt_cycles(halt_cycles),
	.mode_state(mode_state));

`default_nettype wire

// ### sim/swm_ctrl_tb.sv
// Self-checking bench for the sleep and watch mode controller
`timescale 1ns/1ps
`default_nettype none

module swm_ctrl_tb
	import swm_pkg::*;
;
	logic              clock;
	logic              srst;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [DATA_W-1:0] reg_rdata;
	swm_irq_type       irq_req;
	swm_irq_type       irq_set;
	logic              irq_load;
	logic              rst_go;
	logic              reset_source;
	logic [7:0]        core_pin_out;
	logic [7:0]        core_pin_oe;
	logic [3:0]        wake_pin_in;
	logic [7:0]        pin_o;
	logic [7:0]        pin_oe;
	logic [3:0]        wake_pin_live;
	swm_clk_ctrl_type  clk_ctrl;
	logic              retain_en;
	logic              entry_refused;
	logic              cpu_resume;
	logic              sys_reset_req;
	logic [HALT_W-1:0] halt_cycles;
	logic [8:0]        mode_state;
	int                num_errors;
	int                n_checks;

	swm_ctrl #(.PIN_W(8), .IN_W(4)) i_swm_ctrl (
		.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.irq_req(irq_req), .reset_source(reset_source),
		.core_pin_out(core_pin_out), .core_pin_oe(core_pin_oe),
		.wake_pin_in(wake_pin_in), .pin_o(pin_o), .pin_oe(pin_oe),
		.wake_pin_live(wake_pin_live), .clk_ctrl(clk_ctrl), .retain_en(retain_en),
		.entry_refused(entry_refused), .cpu_resume(cpu_resume),
		.sys_reset_req(sys_reset_req), .halt_cycles(halt_cycles),
		.mode_state(mode_state));

	swm_cpu_model i_swm_cpu_model (
		.clock(clock), .srst(srst), .irq_set(irq_set), .irq_load(irq_load),
		.rst_go(rst_go), .cpu_resume(cpu_resume), .irq_req(irq_req),
		.reset_source(reset_source));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic finish_test();
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			num_errors++;
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk({1'b0, reg_rdata}, {1'b0, e});
	endtask

	task automatic irq(input logic p, input logic [2:0] l, input logic [2:0] s);
		@(posedge clock);
		irq_set  <= {p, l, s};
		irq_load <= 1'b1;
		@(posedge clock);
		irq_load <= 1'b0;
		#1;
	endtask

	// Waits a bounded time for a pulse, one edge per step
	task automatic wait_for(input logic use_rst, output int n);
		logic hit;
		hit = use_rst ? sys_reset_req : cpu_resume;
		for (n = 0; n < 8 && hit !== 1'b1; n++) begin
			@(posedge clock);
			#1;
			hit = use_rst ? sys_reset_req : cpu_resume;
		end
		if (hit !== 1'b1) begin
			num_errors++;
			finish_test();
		end
	endtask

	task automatic wake(output int n);
		wait_for(1'b0, n);
		chk(mode_state, ST_WAKE);
		@(posedge clock);
		#1;
		chk(mode_state, ST_RUN);
	endtask

	task automatic stay(input logic [8:0] e);
		repeat (4) @(posedge clock);
		#1;
		chk(mode_state, e);
	endtask

	task automatic t_regs();
		chk({1'b0, clk_ctrl}, 9'h0ef);
		rd(ADDR_PMC, 8'h18);
		wr(ADDR_PMC, 8'h2a);
		rd(ADDR_PMC, 8'h3a);
		chk({7'h0, halt_cycles}, 9'h001);
		wr(4'hf, 8'hff);
		rd(4'hf, 8'h00);
		wr(ADDR_PMC, 8'h08);
		rd(ADDR_PMC, 8'h18);
		rd(ADDR_CLKSEL, 8'h03);
		rd(ADDR_STATUS, 8'h01);
		$display("test regs done");
	endtask

	task automatic t_sleep();
		logic [1:0] sel [3] = '{2'h3, 2'h1, 2'h2};
		logic [8:0] exp [3] = '{ST_SLP_MAIN, ST_SLP_PLL, ST_SLP_SUB};
		int n;
		for (int k = 0; k < 3; k++) begin
			wr(ADDR_CLKSEL, {6'h0, sel[k]});
			core_pin_out <= 8'h5a;
			wr(ADDR_PMC, 8'h48);
			chk(mode_state, exp[k]);
			chk({6'h0, retain_en, clk_ctrl.cpu_clk_en,
			     clk_ctrl.periph_clk_en}, 9'h005);
			core_pin_out <= 8'ha5;
			irq(1'b1, 3'h7, 3'h0);
			stay(exp[k]);
			chk({1'b0, pin_o}, 9'h05a);
			irq(1'b1, 3'h3, 3'h0);
			wake(n);
		end
		wr(ADDR_CLKSEL, 8'h03);
		$display("test sleep done");
	endtask

	task automatic t_prio();
		int n;
		wr(ADDR_PMC, 8'hc8);
		chk(mode_state, ST_STOP);
		irq(1'b1, 3'h2, 3'h1);
		wake(n);
		wr(ADDR_PMC, 8'h40);
		chk(mode_state, ST_TIMEBASE);
		irq(1'b1, 3'h6, 3'h2);
		wake(n);
		$display("test priority done");
	endtask

	task automatic t_watch();
		int n;
		wr(ADDR_CLKSEL, 8'h02);
		core_pin_oe <= 8'h0f;
		wr(ADDR_PMC, 8'h20);
		chk(mode_state, ST_WATCH);
		chk({1'b0, clk_ctrl}, 9'h00d);
		wake_pin_in <= 4'h9;
		irq(1'b1, 3'h1, 3'h2);
		stay(ST_WATCH);
		chk({1'b0, pin_oe}, 9'h000);
		chk({5'h0, wake_pin_live}, 9'h009);
		irq(1'b1, 3'h1, 3'h4);
		wake(n);
		chk(n[8:0], 9'h001);
		wr(ADDR_PMC, 8'h08);
		$display("test watch done");
	endtask

	task automatic t_refuse();
		irq(1'b1, 3'h7, 3'h0);
		wr(ADDR_PMC, 8'h48);
		chk({entry_refused, mode_state[7:0]}, 9'h101);
		wr(ADDR_PMC, 8'h00);
		chk({entry_refused, mode_state[7:0]}, 9'h101);
		irq(1'b0, 3'h0, 3'h0);
		$display("test refuse done");
	endtask

	task automatic t_reset();
		logic [7:0] pmc [2] = '{8'h48, 8'h00};
		int n;
		for (int k = 0; k < 2; k++) begin
			wr(ADDR_CLKSEL, k ? 8'h02 : 8'h01);
			wr(ADDR_PMC, pmc[k]);
			@(posedge clock);
			rst_go <= 1'b1;
			@(posedge clock);
			rst_go <= 1'b0;
			wait_for(1'b1, n);
			chk(mode_state, ST_RESET_SEQ);
			stay(ST_RUN);
			for (n = 0; n < 30000 && reset_source; n++)
				@(posedge clock);
			if (reset_source !== 1'b0) begin
				num_errors++;
				finish_test();
			end
			rd(ADDR_CLKSEL, 8'h03);
		end
		$display("test reset done");
	endtask

	initial begin
		repeat (100000) @(posedge clock);
		num_errors++;
		finish_test();
	end

	initial begin
		num_errors = 0;
		n_checks = 0;
		srst = 1'b1;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		irq_set = '0;
		irq_load = 1'b0;
		rst_go = 1'b0;
		core_pin_out = 8'h00;
		core_pin_oe = 8'hff;
		wake_pin_in = 4'h0;
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		#1;
		t_regs();
		t_sleep();
		t_prio();
		t_watch();
		t_refuse();
		t_reset();
		finish_test();
	end
endmodule

`default_nettype wire

// ### src/swm_ctrl.sv
// Low-power mode sequencer: sleep, timebase, watch and stop control
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module swm_ctrl
	import swm_pkg::*;
#(
	parameter int PIN_W = 8,
	parameter int IN_W  = 4
) (
	input  wire logic                  clock,
	input  wire logic                  srst,
	input  wire logic [ADDR_W-1:0]     reg_addr,
	input  wire logic [DATA_W-1:0]     reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output var  logic [DATA_W-1:0]     reg_rdata,
	input  wire swm_irq_type           irq_req,
	input  wire logic                  reset_source,
	input  wire logic [PIN_W-1:0]      core_pin_out,
	input  wire logic [PIN_W-1:0]      core_pin_oe,
	input  wire logic [IN_W-1:0]       wake_pin_in,
	output var  logic [PIN_W-1:0]      pin_o,
	output var  logic [PIN_W-1:0]      pin_oe,
	output var  logic [IN_W-1:0]       wake_pin_live,
	output var  swm_clk_ctrl_type      clk_ctrl,
	output var  logic                  retain_en,
	output var  logic                  entry_refused,
	output var  logic                  cpu_resume,
	output var  logic                  sys_reset_req,
	output var  logic [HALT_W-1:0]     halt_cycles,
	output var  logic [8:0]            mode_state
);

	initial begin
		if (PIN_W < 1 || IN_W < 1) begin
			$error("PIN_W and IN_W must be at least 1");
		end
	end

	// -------------------------------------------------------------
	// Declarations
	// -------------------------------------------------------------
	swm_state_type    state_reg;
	swm_state_type    state_next;
	logic             pin_state_reg;
	logic [1:0]       halt_reg;
	logic             main_sel_reg;
	logic             sub_sel_reg;
	logic             pmc_write;
	logic             cks_write;
	logic             req_stop;
	logic             req_sleep;
	logic             req_watch;
	logic             level_ok;
	logic             wake_any;
	logic             wake_timebase;
	logic             wake_watch;
	logic             wake_stop;
	logic             in_sleep;
	logic             in_deep;
	logic             refuse_now;
	logic             pin_hold;
	logic             pin_hiz;
	swm_clk_ctrl_type clk_next;
	logic [DATA_W-1:0] rdata_next;

	// -------------------------------------------------------------
	// Write decode
	// -------------------------------------------------------------
	assign pmc_write = reg_wr && (reg_addr == ADDR_PMC)
	                   && (state_reg == ST_RUN);
	assign cks_write = reg_wr && (reg_addr == ADDR_CLKSEL)
	                   && (state_reg == ST_RUN);

	// Mode request bits act on the write only, never stored
	assign req_stop  = reg_wdata[PMC_STOP_BIT];
	assign req_sleep = reg_wdata[PMC_SLEEP_BIT];
	assign req_watch = !reg_wdata[PMC_WATCH_BIT];

	// -------------------------------------------------------------
	// Wake qualification
	// -------------------------------------------------------------
	// Smaller level code means higher priority
	assign level_ok      = irq_req.pending && (irq_req.level < WAKE_LEVEL);
	assign wake_any      = level_ok;
	assign wake_timebase = level_ok && (irq_req.src_watch_timer
	                       || irq_req.src_timebase
	                       || irq_req.src_external);
	// watch wake only timer or external
	assign wake_watch    = level_ok && (irq_req.src_watch_timer
	                       || irq_req.src_external);
	assign wake_stop     = level_ok && irq_req.src_external;

	assign in_sleep = (state_reg == ST_SLP_MAIN)
	                  || (state_reg == ST_SLP_PLL)
	                  || (state_reg == ST_SLP_SUB);
	assign in_deep  = (state_reg == ST_TIMEBASE)
	                  || (state_reg == ST_WATCH)
	                  || (state_reg == ST_STOP);

	// entry refused while a request is pending
	assign refuse_now = pmc_write && irq_req.pending
	                    && (req_stop || req_sleep || req_watch);

	// -------------------------------------------------------------
	// Mode sequencer
	// -------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (pmc_write && !irq_req.pending) begin
					if (req_stop) begin
						state_next = ST_STOP;
					end else if (req_watch) begin
						if (!sub_sel_reg) begin
							state_next = ST_WATCH;
						end else begin
							state_next = ST_TIMEBASE;
						end
					end else if (req_sleep) begin
						if (!sub_sel_reg) begin
							state_next = ST_SLP_SUB;
						end else if (main_sel_reg) begin
							state_next = ST_SLP_MAIN;
						end else begin
							state_next = ST_SLP_PLL;
						end
					end
				end
			end
			ST_SLP_MAIN, ST_SLP_PLL, ST_SLP_SUB: begin
				if (reset_source) begin
					state_next = ST_RESET_SEQ;
				end else if (wake_any) begin
					state_next = ST_WAKE;
				end
			end
			ST_TIMEBASE: begin
				if (reset_source) begin
					state_next = ST_RESET_SEQ;
				end else if (wake_timebase) begin
					state_next = ST_WAKE;
				end
			end
			ST_WATCH: begin
				if (reset_source) begin
					state_next = ST_RESET_SEQ;
				end else if (wake_watch) begin
					state_next = ST_WAKE;
				end
			end
			ST_STOP: begin
				if (reset_source) begin
					state_next = ST_RESET_SEQ;
				end else if (wake_stop) begin
					state_next = ST_WAKE;
				end
			end
			ST_WAKE: begin
				state_next = ST_RUN;
			end
			ST_RESET_SEQ: begin
				state_next = ST_RUN;
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_reg <= ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// -------------------------------------------------------------
	// Stored control fields
	// -------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			pin_state_reg <= PIN_STATE_RST;
			halt_reg      <= HALT_RST;
		end else if (pmc_write) begin
			pin_state_reg <= reg_wdata[PMC_PIN_BIT];
			halt_reg      <= reg_wdata[PMC_HALT_LSB +: HALT_W];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			main_sel_reg <= MAIN_SEL_RST;
			sub_sel_reg  <= SUB_SEL_RST;
		// reset source returns to main clock mode
		end else if (state_next == ST_RESET_SEQ) begin
			main_sel_reg <= MAIN_SEL_RST;
			sub_sel_reg  <= SUB_SEL_RST;
		end else if (cks_write) begin
			main_sel_reg <= reg_wdata[CKS_MAIN_BIT];
			sub_sel_reg  <= reg_wdata[CKS_SUB_BIT];
		end
	end

	// -------------------------------------------------------------
	// Clock gating
	// -------------------------------------------------------------
	always_comb begin
		clk_next.cpu_clk_en     = 1'b1;
		clk_next.periph_clk_en  = 1'b1;
		clk_next.main_osc_en    = 1'b1;
		clk_next.pll_en         = !main_sel_reg && sub_sel_reg;
		clk_next.sub_clk_en     = 1'b1;
		clk_next.watch_timer_en = 1'b1;
		clk_next.timebase_en    = 1'b1;
		clk_next.lvd_en         = 1'b1;
		case (state_next)
			// CPU clock off, peripherals keep running
			ST_SLP_MAIN, ST_SLP_PLL, ST_SLP_SUB: begin
				clk_next.cpu_clk_en = 1'b0;
			end
			ST_TIMEBASE: begin
				clk_next.cpu_clk_en    = 1'b0;
				clk_next.periph_clk_en = 1'b0;
				clk_next.pll_en        = 1'b0;
			end
			ST_WATCH: begin
				clk_next.cpu_clk_en    = 1'b0;
				clk_next.periph_clk_en = 1'b0;
				clk_next.main_osc_en   = 1'b0;
				clk_next.pll_en        = 1'b0;
				clk_next.timebase_en   = 1'b0;
			end
			ST_STOP: begin
				clk_next.cpu_clk_en     = 1'b0;
				clk_next.periph_clk_en  = 1'b0;
				clk_next.main_osc_en    = 1'b0;
				clk_next.pll_en         = 1'b0;
				clk_next.sub_clk_en     = 1'b0;
				clk_next.watch_timer_en = 1'b0;
				clk_next.timebase_en    = 1'b0;
			end
			default: begin
				clk_next.pll_en = !main_sel_reg && sub_sel_reg;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			clk_ctrl <= '{1'b1, 1'b1, 1'b1, 1'b0,
			              1'b1, 1'b1, 1'b1, 1'b1};
		end else begin
			clk_ctrl <= clk_next;
		end
	end

	// -------------------------------------------------------------
	// Status outputs toward the CPU
	// -------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			retain_en     <= 1'b0;
			entry_refused <= 1'b0;
			cpu_resume    <= 1'b0;
			sys_reset_req <= 1'b0;
			mode_state    <= ST_RUN;
			halt_cycles   <= HALT_RST;
		end else begin
			// hold CPU registers and RAM contents
			retain_en     <= (state_next != ST_RUN)
			                 && (state_next != ST_WAKE)
			                 && (state_next != ST_RESET_SEQ);
			entry_refused <= refuse_now;
			// CPU resumes and judges the request
			cpu_resume    <= (state_next == ST_WAKE);
			sys_reset_req <= (state_next == ST_RESET_SEQ);
			mode_state    <= state_next;
			halt_cycles   <= halt_reg;
		end
	end

	// -------------------------------------------------------------
	// Pin control
	// -------------------------------------------------------------
	// sleep holds all pins
	assign pin_hold = in_sleep || in_deep;
	// in timebase, watch and stop, pin select picks hold or high impedance
	assign pin_hiz  = in_deep && pin_state_reg;

	swm_pin_hold #(
		.PIN_W (PIN_W)
	) u_pin_hold (
		.clock    (clock),
		.srst     (srst),
		.core_out (core_pin_out),
		.core_oe  (core_pin_oe),
		.hold     (pin_hold),
		.hiz      (pin_hiz),
		.pin_o    (pin_o),
		.pin_oe   (pin_oe)
	);

	// transfer and interrupt inputs stay live
	always_ff @(posedge clock) begin
		if (srst) begin
			wake_pin_live <= '0;
		end else begin
			wake_pin_live <= wake_pin_in;
		end
	end

	// -------------------------------------------------------------
	// Register read
	// -------------------------------------------------------------
	always_comb begin
		rdata_next = '0;
		case (reg_addr)
			ADDR_PMC: begin
				rdata_next[PMC_STOP_BIT]  = 1'b0;
				rdata_next[PMC_SLEEP_BIT] = 1'b0;
				rdata_next[PMC_PIN_BIT]   = pin_state_reg;
				rdata_next[PMC_SRST_BIT]  = 1'b1;
				rdata_next[PMC_WATCH_BIT] = 1'b1;
				rdata_next[PMC_HALT_LSB +: HALT_W] = halt_reg;
			end
			ADDR_CLKSEL: begin
				rdata_next[CKS_MAIN_BIT] = main_sel_reg;
				rdata_next[CKS_SUB_BIT]  = sub_sel_reg;
			end
			ADDR_STATUS: begin
				rdata_next = state_reg[DATA_W-1:0];
			end
			default: begin
				rdata_next = '0;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= rdata_next;
		end else begin
			reg_rdata <= '0;
		end
	end

endmodule

`default_nettype wire

// ### src/swm_pin_hold.sv
// Per-pin hold and high-impedance control
`timescale 1ns/1ps
`default_nettype none

module swm_pin_hold
	import swm_pkg::*;
#(
	parameter int PIN_W = 8
) (
	input  wire logic             clock,
	input  wire logic             srst,
	input  wire logic [PIN_W-1:0] core_out,
	input  wire logic [PIN_W-1:0] core_oe,
	input  wire logic             hold,
	input  wire logic             hiz,
	output var  logic [PIN_W-1:0] pin_o,
	output var  logic [PIN_W-1:0] pin_oe
);

	initial begin
		if (PIN_W < 1) begin
			$error("PIN_W must be at least 1");
		end
	end

	// -------------------------------------------------------------
	// One flop pair per pin
	// -------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < PIN_W; i++) begin : g_pin
			always_ff @(posedge clock) begin
				if (srst) begin
					pin_o[i]  <= 1'b0;
					pin_oe[i] <= 1'b0;
				end else if (hiz) begin
					pin_oe[i] <= 1'b0;
				end else if (!hold) begin
					pin_o[i]  <= core_out[i];
					pin_oe[i] <= core_oe[i];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// ### src/swm_pkg.sv
// Shared constants and types for the sleep and watch mode controller
package swm_pkg;

	// -------------------------------------------------------------
	// Register map
	// -------------------------------------------------------------
	localparam int          ADDR_W        = 4;
	localparam int          DATA_W        = 8;
	localparam logic [3:0]  ADDR_PMC      = 4'h0;
	localparam logic [3:0]  ADDR_CLKSEL   = 4'h1;
	localparam logic [3:0]  ADDR_STATUS   = 4'h2;

	// -------------------------------------------------------------
	// Power mode control fields
	// -------------------------------------------------------------
	localparam int          PMC_STOP_BIT  = 7;
	localparam int          PMC_SLEEP_BIT = 6;
	localparam int          PMC_PIN_BIT   = 5;
	localparam int          PMC_SRST_BIT  = 4;
	localparam int          PMC_WATCH_BIT = 3;
	localparam int          PMC_HALT_LSB  = 1;
	localparam int          HALT_W        = 2;
	localparam logic        PIN_STATE_RST = 1'b0;
	localparam logic [1:0]  HALT_RST      = 2'h0;

	// -------------------------------------------------------------
	// Clock select fields
	// -------------------------------------------------------------
	localparam int          CKS_MAIN_BIT  = 1;
	localparam int          CKS_SUB_BIT   = 0;
	localparam logic        MAIN_SEL_RST  = 1'b1;
	localparam logic        SUB_SEL_RST   = 1'b1;

	// -------------------------------------------------------------
	// Interrupt wake threshold
	// -------------------------------------------------------------
	localparam int          LEVEL_W       = 3;
	localparam logic [2:0]  WAKE_LEVEL    = 3'h7;

	// -------------------------------------------------------------
	// Mode states, one-hot
	// -------------------------------------------------------------
	typedef enum logic [8:0] {
		ST_RUN       = 9'h001,
		ST_SLP_MAIN  = 9'h002,
		ST_SLP_PLL   = 9'h004,
		ST_SLP_SUB   = 9'h008,
		ST_TIMEBASE  = 9'h010,
		ST_WATCH     = 9'h020,
		ST_STOP      = 9'h040,
		ST_WAKE      = 9'h080,
		ST_RESET_SEQ = 9'h100
	} swm_state_type;

	// -------------------------------------------------------------
	// Carriers
	// -------------------------------------------------------------
	typedef struct packed {
		logic              pending;
		logic [LEVEL_W-1:0] level;
		logic              src_watch_timer;
		logic              src_timebase;
		logic              src_external;
	} swm_irq_type;

	typedef struct packed {
		logic cpu_clk_en;
		logic periph_clk_en;
		logic main_osc_en;
		logic pll_en;
		logic sub_clk_en;
		logic watch_timer_en;
		logic timebase_en;
		logic lvd_en;
	} swm_clk_ctrl_type;

endpackage
